/* File: fpsr_consts.vh */
`ifndef FPSR_CONSTS_VH
`define FPSR_CONSTS_VH
`define FPSR_RD_HI 31
`define FPSR_RD_LO 30
`define FPSR_TEM_HI 27
`define FPSR_TEM_LO 23
`define FPSR_NONSTD_BIT 22
`define FPSR_VER_HI 19
`define FPSR_VER_LO 17
`define FPSR_FTT_HI 16
`define FPSR_FTT_LO 14
`define FPSR_FCC_HI 11
`define FPSR_FCC_LO 10
`define FPSR_AEXC_HI 9
`define FPSR_AEXC_LO 5
`define FPSR_CEXC_HI 4
`define FPSR_CEXC_LO 0
`define FPSR_FTT_NONE 3'h0
`define FPSR_FTT_IEEE 3'h1
`define FPSR_FTT_SEQ 3'h4
`define FPSR_RD_NEAREST 2'h0
`define FPSR_RD_ZERO 2'h1
`define FPSR_RD_PLUS 2'h2
`define FPSR_RD_MINUS 2'h3
`define FPSR_EXC_ZERO 5'h00
`define FPSR_FCC_RESET 2'h0
`define FPSR_VER_DEFAULT 3'h0
`endif

/* File: fpsr_pipe_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fpsr_pipe_model (input wire ref_clk, output logic load_status_insn, output logic store_status_insn,
   output logic float_operate_insn, output logic sequence_error, output logic float_compare_insn,
   output logic float_compare_signal_insn, output logic float_cond_branch_insn, output logic [31:0] load_data,
   output logic [4:0] op_exc, output logic [1:0] compare_result, output logic [3:0] branch_cond);
   // Strobe order: load, store, operate, sequence, compare, signalling compare, branch
   task put(input logic [6:0] s, input logic [31:0] d);
      {load_status_insn, store_status_insn, float_operate_insn, sequence_error, float_compare_insn,
         float_compare_signal_insn, float_cond_branch_insn} = s;
      {load_data, op_exc, compare_result, branch_cond} = {d, d[4:0], d[11:10], d[3:0]};
   endtask
   initial put(7'h00, 32'h0);
endmodule // fpsr_pipe_model
`default_nettype wire

/* File: fpsr_status_control.v */
// Operation
// - Rounding field selects four rounding directions
// - Five-bit mask enables trap per exception
// - Nonstandard mode bit reads zero, ignores writes
// - Trap type held until store or operate
// - Condition codes change only on compares and loads
// - Conditional branch evaluates current condition codes
// - Mask AND current flags nonzero raises trap
// - Otherwise OR current flags into accrued
// - Current flags show latest operate exceptions
// - Absent exceptions clear current flag bits
// - Triple-redundant storage, undefined after power-up except trap type
// - Load and store status need no privilege
// - Trap codes: 0 none, 1 IEEE, 4 sequence
`timescale 1ns/10ps
`default_nettype none
`include "fpsr_consts.vh"
module fpsr_vote3 #(
   parameter W = 32
) (
   input wire [W-1:0] a,
   input wire [W-1:0] b,
   input wire [W-1:0] c,
   output wire [W-1:0] y
);
   assign y = (a & b) | (b & c) | (a & c);
endmodule // fpsr_vote3

module fpsr_tmr_field #(
   parameter W = 5,
   parameter HAS_RESET = 0,
   parameter [W-1:0] RESET_VALUE = {W{1'b0}}
) (
   input wire ref_clk,
   input wire reset,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   // Three copies load together; one upset copy is outvoted
   reg [W-1:0] copy0_ff;
   reg [W-1:0] copy1_ff;
   reg [W-1:0] copy2_ff;

   // Reset reaches only fields that declare one
   always @(posedge ref_clk) begin
      if (reset && HAS_RESET != 0) begin
         copy0_ff <= RESET_VALUE;
      end else begin
         copy0_ff <= d;
      end
   end

   always @(posedge ref_clk) begin
      if (reset && HAS_RESET != 0) begin
         copy1_ff <= RESET_VALUE;
      end else begin
         copy1_ff <= d;
      end
   end

   always @(posedge ref_clk) begin
      if (reset && HAS_RESET != 0) begin
         copy2_ff <= RESET_VALUE;
      end else begin
         copy2_ff <= d;
      end
   end

   fpsr_vote3 #(
      .W(W)
   ) u_vote (
      .a(copy0_ff),
      .b(copy1_ff),
      .c(copy2_ff),
      .y(q)
   );
endmodule // fpsr_tmr_field

module fpsr_status_control #(
   parameter [2:0] VERSION = `FPSR_VER_DEFAULT // Arbitrary value
) (
   input wire ref_clk,
   input wire reset,
   input wire load_status_insn,
   input wire [31:0] load_data,
   input wire store_status_insn,
   input wire float_operate_insn,
   input wire [4:0] op_exc,
   input wire sequence_error,
   input wire float_compare_insn,
   input wire float_compare_signal_insn,
   input wire [1:0] compare_result,
   input wire float_cond_branch_insn,
   input wire [3:0] branch_cond,
   output reg branch_taken_ff,
   output reg float_trap_ff,
   output wire [1:0] round_mode,
   output wire [31:0] fp_status_control
);
   // Exception vectors ordered nv,of,uf,dz,nx in mask, accrued and current fields
   wire [1:0] rd_v;
   wire [4:0] tem_v;
   wire [2:0] ftt_v;
   wire [1:0] fcc_v;
   wire [4:0] aexc_v;
   wire [4:0] cexc_v;
   reg [1:0] nxt_rd;
   reg [4:0] nxt_tem;
   reg [2:0] nxt_ftt;
   reg [1:0] nxt_fcc;
   reg [4:0] nxt_aexc;
   reg [4:0] nxt_cexc;
   reg nxt_trap;
   reg nxt_taken;
   wire [4:0] trap_hits;
   wire any_compare;
   wire op_seq;
   wire op_ieee;
   wire op_clean;
   wire [1:0] load_rd;
   wire [4:0] load_tem;
   wire [1:0] load_fcc;
   wire [4:0] load_aexc;
   wire [4:0] load_cexc;

   // Voting masks a single upset copy; only the trap type field resets, others are undefined after power-up
   fpsr_tmr_field #(
      .W(2)
   ) u_rd (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(nxt_rd),
      .q(rd_v)
   );

   fpsr_tmr_field #(
      .W(5)
   ) u_tem (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(nxt_tem),
      .q(tem_v)
   );

   fpsr_tmr_field #(
      .W(3),
      .HAS_RESET(1),
      .RESET_VALUE(`FPSR_FTT_NONE)
   ) u_ftt (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(nxt_ftt),
      .q(ftt_v)
   );

   fpsr_tmr_field #(
      .W(2)
   ) u_fcc (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(nxt_fcc),
      .q(fcc_v)
   );

   fpsr_tmr_field #(
      .W(5)
   ) u_aexc (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(nxt_aexc),
      .q(aexc_v)
   );

   fpsr_tmr_field #(
      .W(5)
   ) u_cexc (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(nxt_cexc),
      .q(cexc_v)
   );

   assign round_mode = rd_v;
   assign trap_hits = tem_v & op_exc;
   // One operate outcome: sequence error, enabled exception, or clean
   assign any_compare = float_compare_insn | float_compare_signal_insn;
   assign op_seq = float_operate_insn & sequence_error;
   assign op_ieee = float_operate_insn & ~sequence_error & (trap_hits != `FPSR_EXC_ZERO);
   assign op_clean = float_operate_insn & ~sequence_error & (trap_hits == `FPSR_EXC_ZERO);
   // Nonstandard bit and version are not writable
   assign load_rd = load_data[`FPSR_RD_HI:`FPSR_RD_LO];
   assign load_tem = load_data[`FPSR_TEM_HI:`FPSR_TEM_LO];
   assign load_fcc = load_data[`FPSR_FCC_HI:`FPSR_FCC_LO];
   assign load_aexc = load_data[`FPSR_AEXC_HI:`FPSR_AEXC_LO];
   assign load_cexc = load_data[`FPSR_CEXC_HI:`FPSR_CEXC_LO];

   // Reserved bits and version are fixed; only voted fields vary
   assign fp_status_control[`FPSR_RD_HI:`FPSR_RD_LO] = rd_v;
   assign fp_status_control[`FPSR_RD_LO-1:`FPSR_TEM_HI+1] = 2'h0;
   assign fp_status_control[`FPSR_TEM_HI:`FPSR_TEM_LO] = tem_v;
   assign fp_status_control[`FPSR_NONSTD_BIT] = 1'b0;
   assign fp_status_control[`FPSR_NONSTD_BIT-1:`FPSR_VER_HI+1] = 2'h0;
   assign fp_status_control[`FPSR_VER_HI:`FPSR_VER_LO] = VERSION;
   assign fp_status_control[`FPSR_FTT_HI:`FPSR_FTT_LO] = ftt_v;
   assign fp_status_control[`FPSR_FTT_LO-1:`FPSR_FCC_HI+1] = 2'h0;
   assign fp_status_control[`FPSR_FCC_HI:`FPSR_FCC_LO] = fcc_v;
   assign fp_status_control[`FPSR_AEXC_HI:`FPSR_AEXC_LO] = aexc_v;
   assign fp_status_control[`FPSR_CEXC_HI:`FPSR_CEXC_LO] = cexc_v;

   // Load and store status carry no privilege check
   // Rounding direction and mask change only by load
   always @* begin
      nxt_rd = rd_v;
      if (load_status_insn) begin
         nxt_rd = load_rd;
      end
   end

   // Trap enables, one per exception
   always @* begin
      nxt_tem = tem_v;
      if (load_status_insn) begin
         nxt_tem = load_tem;
      end
   end

   // A compare in the same cycle as a load wins the condition codes
   always @* begin
      nxt_fcc = fcc_v;
      if (load_status_insn) begin
         nxt_fcc = load_fcc;
      end
      if (any_compare) begin
         nxt_fcc = compare_result;
      end
   end

   // An operate in the load cycle accrues on top of the loaded value
   always @* begin
      nxt_aexc = aexc_v;
      if (load_status_insn) begin
         nxt_aexc = load_aexc;
      end
      if (op_clean) begin
         nxt_aexc = nxt_aexc | op_exc;
      end
   end

   // Current flags follow the latest operate, or the loaded value when no operate
   always @* begin
      nxt_cexc = cexc_v;
      if (load_status_insn) begin
         nxt_cexc = load_cexc;
      end
      if (float_operate_insn) begin
         nxt_cexc = op_exc;
      end
   end

   // Load cannot write the trap type; a later operate overrides a store clear
   always @* begin
      nxt_ftt = ftt_v;
      if (store_status_insn) begin
         nxt_ftt = `FPSR_FTT_NONE;
      end
      if (op_seq) begin
         nxt_ftt = `FPSR_FTT_SEQ;
      end else if (op_ieee) begin
         nxt_ftt = `FPSR_FTT_IEEE;
      end else if (op_clean) begin
         nxt_ftt = `FPSR_FTT_NONE;
      end
   end

   always @* begin
      nxt_trap = op_seq | op_ieee;
   end

   // Branch condition bit n selects fcc value n
   always @* begin
      nxt_taken = float_cond_branch_insn & branch_cond[fcc_v];
   end

   // Trap and branch results stand for one cycle
   always @(posedge ref_clk) begin
      if (reset) begin
         float_trap_ff <= 1'b0;
      end else begin
         float_trap_ff <= nxt_trap;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         branch_taken_ff <= 1'b0;
      end else begin
         branch_taken_ff <= nxt_taken;
      end
   end
endmodule // fpsr_status_control
`default_nettype wire

/* File: fpsr_status_control_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module fpsr_sc_asserts (
   input wire ref_clk, input wire reset, input wire load_status_insn, input wire store_status_insn,
   input wire float_operate_insn, input wire [4:0] op_exc, input wire sequence_error, input wire float_compare_insn,
   input wire float_compare_signal_insn, input wire float_cond_branch_insn, input wire [3:0] branch_cond,
   input wire branch_taken_ff, input wire float_trap_ff, input wire [31:0] fp_status_control);
   wire [31:0] f = fp_status_control;
   wire op = float_operate_insn && !load_status_insn;
   wire hit = |(op_exc & f[27:23]);
   logic seen_ff = 1'b0;
   // Fields are unreset, so most checks wait for the first load
   always_ff @(posedge ref_clk) seen_ff <= seen_ff | load_status_insn;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   trap_raise_a: assert property (
      seen_ff && !load_status_insn |=> float_trap_ff == $past(op && (sequence_error || hit))) else $error("trap");
   cexc_new_a: assert property (
      op && !sequence_error |=> f[4:0] == $past(op_exc)) else $error("cexc");
   aexc_or_a: assert property (
      seen_ff && op && !sequence_error && !hit |=> f[9:5] == $past(f[9:5] | op_exc)) else $error("aexc");
   trap_type_a: assert property (
      seen_ff && op |=> f[16:14] == $past(sequence_error ? 3'h4 : {2'h0, hit})) else $error("ftt");
   store_clear_a: assert property (
      store_status_insn && !float_operate_insn |=> f[16:14] == 3'h0) else $error("st");
   nonstd_zero_a: assert property (f[22] == 1'b0) else $error("nonstd");
   fcc_hold_a: assert property (
      seen_ff && !float_compare_insn && !float_compare_signal_insn && !load_status_insn
      |=> $stable(f[11:10])) else $error("fcc");
   branch_eval_a: assert property (
      seen_ff |=> branch_taken_ff == $past(float_cond_branch_insn && branch_cond[f[11:10]])) else $error("br");
   cover property (op && hit);
   cover property (op && !hit && op_exc != 5'h00);
   cover property (branch_taken_ff);
endmodule // fpsr_sc_asserts
bind fpsr_status_control fpsr_sc_asserts fpsr_sc_asserts_inst (.*);
`default_nettype wire

/* File: fpsr_status_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module fpsr_status_control_bench;
   logic ref_clk = 1'b0, reset = 1'b1;
   wire load_status_insn, store_status_insn, float_operate_insn, sequence_error, float_compare_insn;
   wire float_compare_signal_insn, float_cond_branch_insn, branch_taken_ff, float_trap_ff;
   wire [31:0] load_data, fp_status_control;
   wire [4:0] op_exc;
   wire [3:0] branch_cond;
   wire [1:0] compare_result, round_mode;
   int err_total = 0, tests_run = 0;
   logic [31:0] w;
   logic [4:0] e;
   fpsr_status_control fpsr_status_control_inst (.*);
   fpsr_pipe_model fpsr_pipe_model_inst (.*);
   initial forever #2.5 ref_clk = ~ref_clk;
   task go(input logic [6:0] s, input logic [31:0] d);
      @(negedge ref_clk);
      fpsr_pipe_model_inst.put(s, d);
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] y);
      tests_run++;
      if (x !== y) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, x, y);
      end
   endtask
   function logic [31:0] op_word(input logic [31:0] v, input logic [4:0] x);
      op_word = {v[31:17], 2'h0, |(x & v[27:23]), v[13:10], |(x & v[27:23]) ? v[9:5] : v[9:5] | x, x};
   endfunction
   task finish_test;
      if (err_total == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      w = $urandom(32'hbea7);
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      for (int i = 0; i < 40; i++) begin
         w = i ? $urandom : 32'hffff_ffff;
         e = $urandom;
         go(7'h60, w);
         go(7'h10, {27'h0, e});
         chk("ld", w & 32'hcf80_0fff, fp_status_control);
         go(e[0] ? 7'h08 : 7'h04, w);
         chk("op", op_word(w & 32'hcf80_0fff, e), fp_status_control);
         chk("trap", |(e & w[27:23]), float_trap_ff);
         chk("rd", w[31:30], round_mode);
         go(e[1] ? 7'h04 : 7'h02, {20'h0, e[4:3], 10'h0});
         go(7'h01, w);
         chk("fcc", e[4:3], fp_status_control[11:10]);
         go(7'h00, ~w);
         chk("br", w[e[4:3]], branch_taken_ff);
         chk("fcc_hold", e[4:3], fp_status_control[11:10]);
      end
      go(7'h18, 32'h0);
      go(7'h00, 32'h0);
      chk("seq", 3'h4, fp_status_control[16:14]);
      chk("seq_trap", 1'b1, float_trap_ff);
      finish_test;
   end
endmodule // fpsr_status_control_bench
`default_nettype wire
